// ===== verilog/decrement_skip_exec.v
// Execution unit for the three decrement instructions with bus access to its state.
//
// What this block does
// [RQ1] Each decrement reads the addressed file register and forms its value minus one.
// [RQ2] Destination bit zero: result goes to the working register, file unchanged.
// [RQ3] Destination bit one: result is written back into the same file register.
// [RQ4] Bank mode bit zero: operand lies in the fixed low bank, bank select ignored.
// [RQ5] Bank mode bit one: address is bank select register joined to 8-bit address.
// [RQ6] Skip-zero discards the fetched next instruction only when the result is zero.
// [RQ7] Skip-nonzero discards the fetched next instruction only when result is nonzero.
// [RQ8] A taken skip runs one idle cycle instead, two cycles in total.
// [RQ9] Each decrement is one word and takes one instruction cycle without a skip.
// [RQ10] A skip over a two-word instruction idles both words, three cycles total.
// [RQ11] Decode prefixes 000001, 001011, 010011; only the plain decrement updates flags.
// [RQ12] Q1 decodes, Q2 reads the file, Q3 computes, Q4 writes the destination.
module decrement_skip_exec
#(
   parameter BANK_BITS = 4
)
(
   input  wire                   clk,
   input  wire                   arst_n,
   input  wire [15:0]            instr_word,
   input  wire                   instr_valid,
   output wire                   instr_ready,
   input  wire                   next_two_word,
   output reg                    skip_req_ff,
   output reg                    cycle_done_ff,
   output wire                   busy,
   input  wire [2:0]             avs_address,
   input  wire                   avs_read,
   input  wire                   avs_write,
   input  wire [31:0]            avs_writedata,
   output wire [31:0]            avs_readdata,
   output wire                   avs_waitrequest
);

`include "decrement_skip_defs.vh"

   localparam ADDR_BITS = BANK_BITS + 8;
   localparam DEPTH     = 1 << ADDR_BITS;

   // The core is idle, in its own cycle, or in the first or second discarded cycle.
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_NOP1 = 2'h2;
   localparam ST_NOP2 = 2'h3;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   // Only the upper six bits tell the three decrements apart from every other opcode.
   function [1:0] decode_kind;
      input [15:0] word;
      begin
         case (word[`OPC_MSB:`OPC_LSB])
            `OPC_PLAIN_DECREMENT:  decode_kind = `KIND_PLAIN;
            `OPC_DEC_SKIP_ZERO:    decode_kind = `KIND_SKIP_ZERO;
            `OPC_DEC_SKIP_NONZERO: decode_kind = `KIND_SKIP_NONZERO;
            default:               decode_kind = `KIND_OTHER;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // The file memory has no reset; software loads it over the bus before use.
   reg  [7:0]              file_mem [0:DEPTH-1];
   reg  [1:0]              state_ff;
   reg  [15:0]             instr_ff;
   reg  [1:0]              kind_ff;
   reg                     dest_file_ff;
   reg  [ADDR_BITS-1:0]    operand_addr_ff;
   reg  [7:0]              operand_ff;
   reg  [7:0]              result_ff;
   reg  [`FLG_WIDTH-1:0]   alu_flags_ff;
   reg  [7:0]              working_ff;
   reg  [BANK_BITS-1:0]    bank_select_ff;
   reg  [`FLG_WIDTH-1:0]   status_ff;
   reg  [ADDR_BITS-1:0]    mem_addr_ff;
   reg                     two_word_ff;
   reg                     ack_ff;
   reg  [31:0]             readdata_ff;

   reg  [1:0]              nxt_state;
   wire [1:0]              phase;
   wire                    last_phase;
   wire [7:0]              alu_result;
   wire [`FLG_WIDTH-1:0]   alu_flags;
   wire                    skip_now;
   wire                    finishing;
   wire                    accept;
   wire                    bus_req;
   wire                    bus_take;
   wire                    core_q4;

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   q_phase_counter u_phase
   (
      .clk        (clk),
      .arst_n     (arst_n),
      .run        (state_ff != ST_IDLE),
      .phase_ff   (phase),
      .last_phase (last_phase)
   );

   decrement_alu u_alu
   (
      .operand (operand_ff),
      .result  (alu_result),
      .flags   (alu_flags)
   );

   // Q4 of a real instruction cycle; all destination writes happen at its closing edge.
   assign core_q4 = (state_ff == ST_EXEC) && last_phase;

   // Skip decision is taken on the result held since Q3.
   assign skip_now = core_q4 &&
                     (((kind_ff == `KIND_SKIP_ZERO) && (result_ff == 8'h00)) || // RQ6
                      ((kind_ff == `KIND_SKIP_NONZERO) && (result_ff != 8'h00)));   // RQ7

   // The cycle ends at Q4 unless idle cycles still follow.
   assign finishing = (core_q4 && !skip_now) ||                                // RQ9
                      ((state_ff == ST_NOP1) && last_phase && !two_word_ff) ||
                      ((state_ff == ST_NOP2) && last_phase);

   // A request held during the final Q4 is taken at once, so instructions run back to back.
   assign busy        = (state_ff != ST_IDLE);
   assign instr_ready = (state_ff == ST_IDLE) || finishing;
   assign accept      = instr_valid && instr_ready;

   // ----------------------------------------------------------------
   // Instruction state machine
   // ----------------------------------------------------------------
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (accept)
               nxt_state = ST_EXEC;
         ST_EXEC:
            if (skip_now)
               nxt_state = ST_NOP1;                                            // RQ8
            else if (last_phase)
               nxt_state = accept ? ST_EXEC : ST_IDLE;
         ST_NOP1:
            if (last_phase && two_word_ff)
               nxt_state = ST_NOP2;                                            // RQ10
            else if (last_phase)
               nxt_state = accept ? ST_EXEC : ST_IDLE;
         ST_NOP2:
            if (last_phase)
               nxt_state = accept ? ST_EXEC : ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff      <= ST_IDLE;
         instr_ff      <= 16'h0000;
         two_word_ff   <= 1'b0;
         skip_req_ff   <= 1'b0;
         cycle_done_ff <= 1'b0;
      end
      else
      begin
         state_ff      <= nxt_state;
         skip_req_ff   <= skip_now;
         cycle_done_ff <= finishing;
         if (accept)
            instr_ff <= instr_word;
         // The width of the following instruction is only known at the Q4 of a taking skip.
         if (skip_now)
            two_word_ff <= next_two_word;                                      // RQ10
      end
   end

   // ----------------------------------------------------------------
   // Data path per phase
   // ----------------------------------------------------------------
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         kind_ff         <= `KIND_OTHER;
         dest_file_ff    <= 1'b0;
         operand_addr_ff <= {ADDR_BITS{1'b0}};
         operand_ff      <= 8'h00;
         result_ff       <= 8'h00;
         alu_flags_ff    <= `RST_STATUS;
      end
      else if (state_ff == ST_EXEC)
      begin
         // Each phase loads one stage, so the Q4 write sees values settled a clock earlier.
         case (phase)
            `PH_Q1:
            begin
               kind_ff      <= decode_kind(instr_ff);                         // RQ11
               dest_file_ff <= instr_ff[`DEST_BIT];
               if (instr_ff[`BANK_MODE_BIT])
                  operand_addr_ff <= {bank_select_ff, instr_ff[7:0]};          // RQ5
               else
                  operand_addr_ff <= {`FIXED_LOW_BANK, instr_ff[7:0]};         // RQ4
            end
            `PH_Q2:
               operand_ff <= file_mem[operand_addr_ff];                        // RQ12
            `PH_Q3:
            begin
               result_ff    <= alu_result;                                     // RQ1
               alu_flags_ff <= alu_flags;
            end
            default:
               result_ff <= result_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // A bus access is only acknowledged in an idle clock, so software sees whole cycles.
   // With the core idle the slave answers one clock after the request, which lets the read mux be registered.
   assign bus_req         = avs_read || avs_write;
   assign bus_take        = bus_req && ack_ff;
   assign avs_waitrequest = bus_req && !ack_ff;
   assign avs_readdata    = readdata_ff;

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack_ff      <= 1'b0;
         readdata_ff <= 32'h00000000;
      end
      else
      begin
         ack_ff <= bus_req && !ack_ff && (state_ff == ST_IDLE);
         if (bus_req && !ack_ff)
         begin
            case (avs_address)
               `REG_WORKING:     readdata_ff <= {24'h000000, working_ff};
               `REG_BANK_SELECT: readdata_ff <= {{(32-BANK_BITS){1'b0}}, bank_select_ff};
               `REG_STATUS:      readdata_ff <= {{(32-`FLG_WIDTH){1'b0}}, status_ff};
               `REG_MEM_ADDR:    readdata_ff <= {{(32-ADDR_BITS){1'b0}}, mem_addr_ff};
               `REG_MEM_DATA:    readdata_ff <= {24'h000000, file_mem[mem_addr_ff]};
               `REG_CORE_STATE:  readdata_ff <= {30'h00000000, state_ff};
               default:          readdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Architectural registers, written in Q4 or by the bus
   // ----------------------------------------------------------------
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         working_ff     <= `RST_WORKING;
         bank_select_ff <= `RST_BANK_SELECT;
         status_ff      <= `RST_STATUS;
         mem_addr_ff    <= `RST_MEM_ADDR;
      end
      else
      begin
         // Q4 writes take priority; a bus write cannot meet them as the bus is only acknowledged in an idle clock.
         if (core_q4 && !dest_file_ff && (kind_ff != `KIND_OTHER))
            working_ff <= result_ff;                                           // RQ2
         else if (bus_take && avs_write && (avs_address == `REG_WORKING))
            working_ff <= avs_writedata[7:0];
         if (core_q4 && (kind_ff == `KIND_PLAIN))
            status_ff <= alu_flags_ff;                                         // RQ11
         else if (bus_take && avs_write && (avs_address == `REG_STATUS))
            status_ff <= avs_writedata[`FLG_WIDTH-1:0];
         if (bus_take && avs_write && (avs_address == `REG_BANK_SELECT))
            bank_select_ff <= avs_writedata[BANK_BITS-1:0];
         if (bus_take && avs_write && (avs_address == `REG_MEM_ADDR))
            mem_addr_ff <= avs_writedata[ADDR_BITS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // File memory
   // ----------------------------------------------------------------
   // It has no reset, so it can map onto a plain synchronous RAM.
   always @(posedge clk)
   begin
      if (core_q4 && dest_file_ff && (kind_ff != `KIND_OTHER))
         file_mem[operand_addr_ff] <= result_ff;                               // RQ3
      else if (bus_take && avs_write && (avs_address == `REG_MEM_DATA))
         file_mem[mem_addr_ff] <= avs_writedata[7:0];
   end

endmodule

// ===== verilog/decrement_skip_defs.vh
// Shared constants for the decrement and skip execution block.
`ifndef DECREMENT_SKIP_DEFS_VH
`define DECREMENT_SKIP_DEFS_VH

// ----------------------------------------------------------------
// Opcode prefixes, upper six bits of the instruction word
// ----------------------------------------------------------------
`define OPC_PLAIN_DECREMENT   6'h01
`define OPC_DEC_SKIP_ZERO     6'h0b
`define OPC_DEC_SKIP_NONZERO  6'h13
`define OPC_MSB               15
`define OPC_LSB               10
`define DEST_BIT              9
`define BANK_MODE_BIT         8

// ----------------------------------------------------------------
// Decoded instruction kinds
// ----------------------------------------------------------------
`define KIND_OTHER            2'h0
`define KIND_PLAIN            2'h1
`define KIND_SKIP_ZERO        2'h2
`define KIND_SKIP_NONZERO     2'h3

// ----------------------------------------------------------------
// Phases within one instruction cycle
// ----------------------------------------------------------------
`define PH_Q1                 2'h0
`define PH_Q2                 2'h1
`define PH_Q3                 2'h2
`define PH_Q4                 2'h3

// ----------------------------------------------------------------
// Status flag positions
// ----------------------------------------------------------------
`define FLG_CARRY             0
`define FLG_HALF_CARRY        1
`define FLG_ZERO              2
`define FLG_SIGNED_WRAP       3
`define FLG_NEGATIVE          4
`define FLG_WIDTH             5

// ----------------------------------------------------------------
// Register word indices on the bus
// ----------------------------------------------------------------
`define REG_WORKING           3'h0
`define REG_BANK_SELECT       3'h1
`define REG_STATUS            3'h2
`define REG_MEM_ADDR          3'h3
`define REG_MEM_DATA          3'h4
`define REG_CORE_STATE        3'h5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_WORKING           8'h00
`define RST_BANK_SELECT       4'h0
`define RST_STATUS            5'h00
`define RST_MEM_ADDR          12'h000
`define FIXED_LOW_BANK        4'h0

`endif

// ===== verilog/q_phase_counter.v
// Four-phase sequencer that divides an instruction cycle into Q1 to Q4.
module q_phase_counter
(
   input  wire       clk,
   input  wire       arst_n,
   input  wire       run,
   output reg  [1:0] phase_ff,
   output wire       last_phase
);

`include "decrement_skip_defs.vh"

   wire [1:0] nxt_phase;

   assign nxt_phase  = run ? phase_ff + 2'h1 : `PH_Q1;
   assign last_phase = run && (phase_ff == `PH_Q4);

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         phase_ff <= `PH_Q1;
      else
         phase_ff <= nxt_phase;
   end

endmodule

// ===== verilog/decrement_alu.v
// Decrement data path with its arithmetic flags.
`include "decrement_skip_defs.vh"
module decrement_alu
(
   input  wire [7:0]             operand,
   output wire [7:0]             result,
   output wire [`FLG_WIDTH-1:0]  flags
);

   wire [8:0] sum;
   wire [4:0] low_sum;

   // Subtracting one is adding all ones; the carry is then the no-borrow flag.
   assign sum     = {1'b0, operand} + 9'h0ff;
   assign low_sum = {1'b0, operand[3:0]} + 5'h0f;
   assign result  = sum[7:0];

   assign flags[`FLG_CARRY]       = sum[8];
   assign flags[`FLG_HALF_CARRY]  = low_sum[4];
   assign flags[`FLG_ZERO]        = (sum[7:0] == 8'h00);
   assign flags[`FLG_SIGNED_WRAP] = operand[7] & ~sum[7];
   assign flags[`FLG_NEGATIVE]    = sum[7];

endmodule

// ===== verilog/dummy_never.v
// Intentionally empty; the block needs no module beyond its three design files.

// ===== sim/decrement_skip_exec_chk.sv
// Port-level timing checks for the decrement and skip execution block.
`include "decrement_skip_defs.vh"
module decrement_skip_exec_chk
(
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic [15:0] instr_word,
   input wire logic        instr_valid,
   input wire logic        instr_ready,
   input wire logic        next_two_word,
   input wire logic        skip_req_ff,
   input wire logic        cycle_done_ff,
   input wire logic        busy,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest
);
   timeunit 1ns;
   timeprecision 100ps;
   wire       acc = instr_valid && instr_ready;
   wire [5:0] op  = instr_word[15:10];
   wire       skp = op == `OPC_DEC_SKIP_ZERO || op == `OPC_DEC_SKIP_NONZERO;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_four_phases; acc |=> busy [*4]; endproperty
   property p_one_cycle; acc && !skp |-> ##5 (cycle_done_ff && !skip_req_ff); endproperty
   property p_skip_decides; acc && skp |-> ##5 (skip_req_ff ^ cycle_done_ff); endproperty
   property p_skip_pulse; skip_req_ff |=> !skip_req_ff [*4]; endproperty
   property p_skip_busy; skip_req_ff |-> busy [*4]; endproperty
   property p_one_word; skip_req_ff && !$past(next_two_word) |-> ##4 cycle_done_ff; endproperty
   property p_two_word; skip_req_ff && $past(next_two_word) |-> ##8 cycle_done_ff; endproperty
   property p_ready_idle; !busy |-> instr_ready && !skip_req_ff; endproperty
   property p_bus_wait; busy && (avs_read || avs_write) |-> avs_waitrequest; endproperty
   a_four_phases: assert property (p_four_phases)
      else $error("busy not held for four clocks");
   a_one_cycle: assert property (p_one_cycle)
      else $error("single cycle instruction did not finish in one cycle");
   a_skip_decides: assert property (p_skip_decides)
      else $error("skip instruction neither skipped nor finished");
   a_skip_pulse: assert property (p_skip_pulse)
      else $error("skip request repeated too soon");
   a_skip_busy: assert property (p_skip_busy)
      else $error("idle cycle shorter than four clocks");
   a_one_word: assert property (p_one_word)
      else $error("skip over one word not two cycles");
   a_two_word: assert property (p_two_word)
      else $error("skip over two words not three cycles");
   a_ready_idle: assert property (p_ready_idle)
      else $error("not ready or still skipping while idle");
   a_bus_wait: assert property (p_bus_wait)
      else $error("bus answered while core busy");
   c_plain: cover property (acc && op == `OPC_PLAIN_DECREMENT);
   c_skip: cover property (skip_req_ff);
   c_two: cover property (skip_req_ff && $past(next_two_word));
endmodule

bind decrement_skip_exec decrement_skip_exec_chk u_chk
(
   .clk             (clk),
   .arst_n          (arst_n),
   .instr_word      (instr_word),
   .instr_valid     (instr_valid),
   .instr_ready     (instr_ready),
   .next_two_word   (next_two_word),
   .skip_req_ff     (skip_req_ff),
   .cycle_done_ff   (cycle_done_ff),
   .busy            (busy),
   .avs_read        (avs_read),
   .avs_write       (avs_write),
   .avs_waitrequest (avs_waitrequest)
);

// ===== sim/decrement_skip_exec_bench.sv
// Self-checking bench for the decrement and skip execution block.
`include "decrement_skip_defs.vh"
`define CHK(nm, e, g) \
   begin \
      n_checks++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("[FAIL] %s expected %h seen %h", nm, e, g); \
      end \
   end
module decrement_skip_exec_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk;
   logic        arst_n;
   logic [15:0] instr_word;
   logic        instr_valid;
   logic        next_two_word;
   logic [2:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   wire         instr_ready;
   wire         skip_req_ff;
   wire         cycle_done_ff;
   wire         busy;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cyc = 0;
   logic [31:0] rd;
   logic [5:0]  ops [4] = '{`OPC_PLAIN_DECREMENT, `OPC_DEC_SKIP_ZERO, `OPC_DEC_SKIP_NONZERO, 6'h3f};
   logic [7:0]  ev [4]  = '{8'h00, 8'h01, 8'h80, 8'h10};

   decrement_skip_exec dut
   (
      .clk             (clk),
      .arst_n          (arst_n),
      .instr_word      (instr_word),
      .instr_valid     (instr_valid),
      .instr_ready     (instr_ready),
      .next_two_word   (next_two_word),
      .skip_req_ff     (skip_req_ff),
      .cycle_done_ff   (cycle_done_ff),
      .busy            (busy),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Bus and instruction drivers
   // ----------------------------------------------------------------
   task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !wr;
      avs_write     <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic exec(input logic [15:0] w, input logic two, output int n, output logic sk);
      @(posedge clk);
      instr_word    <= w;
      instr_valid   <= 1'b1;
      next_two_word <= two;
      @(posedge clk);
      while (instr_ready !== 1'b1)
         @(posedge clk);
      instr_valid <= 1'b0;
      n  = 0;
      sk = 1'b0;
      while (cycle_done_ff !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
         #1;
         if (skip_req_ff === 1'b1)
            sk = 1'b1;
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] r;
      logic [7:0]  f, v, res, w0;
      logic [3:0]  b;
      logic [4:0]  st, flg;
      logic [11:0] tgt, alt;
      logic [5:0]  op;
      logic        a, d, two, sk, tk;
      int          k, n, en;
      arst_n = 1'b0;
      instr_word = 16'h0000;
      instr_valid = 1'b0;
      next_two_word = 1'b0;
      avs_address = 3'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      r = $urandom(2);
      // Registers read zero after reset; index 6 is unmapped; file word 0 has no reset.
      bus(1'b1, `REG_MEM_DATA, 32'h0);
      for (k = 0; k < 7; k++)
      begin
         bus(1'b0, 3'(k), 32'h0);
         `CHK("reset read", 32'h0, rd)
      end
      bus(1'b1, 3'h7, 32'hffffffff);
      bus(1'b0, 3'h7, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      for (k = 0; k < 48; k++)
      begin
         r   = $urandom;
         op  = ops[k % 4];
         v   = (k < 16) ? ev[(k / 4) % 4] : r[31:24];
         f   = r[7:0];
         a   = r[8];
         d   = r[9];
         two = r[10];
         b   = (r[14:11] == 4'h0) ? 4'h1 : r[14:11];
         w0  = r[22:15];
         st  = r[27:23];
         tgt = a ? {b, f} : {`FIXED_LOW_BANK, f};
         alt = a ? {`FIXED_LOW_BANK, f} : {b, f};
         bus(1'b1, `REG_BANK_SELECT, {28'h0, b});
         bus(1'b1, `REG_MEM_ADDR, {20'h0, alt});
         bus(1'b1, `REG_MEM_DATA, {24'h0, ~v});
         bus(1'b1, `REG_MEM_ADDR, {20'h0, tgt});
         bus(1'b1, `REG_MEM_DATA, {24'h0, v});
         bus(1'b1, `REG_WORKING, {24'h0, w0});
         bus(1'b1, `REG_STATUS, {27'h0, st});
         exec({op, d, a, f}, two, n, sk);
         res = v - 8'h01;
         tk  = (op == `OPC_DEC_SKIP_ZERO && res == 8'h00) ||
               (op == `OPC_DEC_SKIP_NONZERO && res != 8'h00);
         en  = tk ? (two ? 12 : 8) : 4;
         flg = (op == `OPC_PLAIN_DECREMENT) ?
               {res[7], v == 8'h80, res == 8'h00, v[3:0] != 4'h0, v != 8'h00} : st;
         `CHK("skip taken", tk, sk)
         `CHK("cycle count", en, n)
         bus(1'b0, `REG_STATUS, 32'h0);
         `CHK("status", {27'h0, flg}, rd)
         bus(1'b0, `REG_WORKING, 32'h0);
         `CHK("working", {24'h0, (op != 6'h3f && !d) ? res : w0}, rd)
         bus(1'b0, `REG_MEM_DATA, 32'h0);
         `CHK("file", {24'h0, (op != 6'h3f && d) ? res : v}, rd)
         bus(1'b1, `REG_MEM_ADDR, {20'h0, alt});
         bus(1'b0, `REG_MEM_DATA, 32'h0);
         `CHK("other bank", {24'h0, ~v}, rd)
         $display("test %0d done", k);
      end
      summarize();
   end
endmodule
